// ===== rtl/serial_consts.svh
// Register offsets, field positions, reset values and timing counts of the serial unit.
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define IDX_FRC_HI        8'h09
`define IDX_FRC_LO        8'h0A
`define IDX_RATE          8'h10
`define IDX_XFER          8'h11
`define IDX_TX_DATA       8'h12
`define IDX_RX_DATA       8'h13
`define IDX_IRQ_STATUS    8'h14
`define IDX_IRQ_CLEAR     8'h15
`define IDX_IRQ_ENABLE    8'h16

// ==========================================================================
// Field positions and reset values
`define XFER_TX_EN_BIT    0
`define XFER_RX_EN_BIT    1
`define XFER_TX_EMPTY_BIT 2
`define XFER_RX_FULL_BIT  3
`define XFER_TX_BUSY_BIT  4
`define XFER_RX_BUSY_BIT  5
`define IRQ_TX_EMPTY_BIT  0
`define IRQ_RX_FULL_BIT   1
`define IRQ_OVERRUN_BIT   2
`define IRQ_FRAMING_BIT   3
`define RATE_RESET        8'h00
`define FRC_PRESET        16'hFFF8
`define FRC_RESET         16'h0000

// ==========================================================================
// Timing counts
`define OVERSAMPLE        4'h8
`define FRAME_BITS        4'hA
`define MID_SAMPLE        3'h4

`endif

// ===== rtl/serial_pkg.sv
// Types shared by the serial unit files.
package serial_pkg;
	typedef enum logic [1:0] {
		TX_IDLE     = 2'b00,
		TX_PREAMBLE = 2'b01,
		TX_SHIFT    = 2'b10
	} tx_state_e;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_e;
endpackage

// ===== rtl/rate_tick_if.sv
// Carries the oversample tick from the counter to the serial shifters.
`timescale 1ns/1ns
interface rate_tick_if;
	logic       sample_tick;
	logic [3:0] sample_phase;
	modport source (output sample_tick, output sample_phase);
	modport sink   (input sample_tick, input sample_phase);
endinterface

// ===== rtl/free_run_counter.sv
// Free-running counter with coherent read latch and baud tick generation.
`timescale 1ns/1ns
`include "serial_consts.svh"
module free_run_counter (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        rd_hi,
	input  wire logic        wr_hi,
	input  wire logic        wr_lo,
	input  wire logic [7:0]  wdata,
	input  wire logic [7:0]  rate_sel,
	output logic      [15:0] count,
	output logic      [7:0]  lo_latch,
	rate_tick_if.source      tick
);
	typedef struct packed {
		logic [15:0] count;
		logic [7:0]  lo_latch;
		logic [7:0]  hi_pending;
		logic        hi_written;
		logic        hold;
		logic        tick_q;
		logic [3:0]  phase;
	} frc_s;

	frc_s state_reg;
	frc_s state_next;
	logic tap;

	// ==========================================================================
	// Counter
	// The tap bit selects the oversample rate; a counter write moves it too.
	assign tap = state_reg.count[rate_sel[3:0]];
	always_comb begin
		state_next = state_reg;
		state_next.hold = 1'b0;
		if (!state_reg.hold) begin
			state_next.count = state_reg.count + 16'h0001;
		end
		if (rd_hi) begin
			state_next.lo_latch = state_reg.count[7:0];
		end
		if (wr_hi) begin
			state_next.count = `FRC_PRESET;
			state_next.hi_pending = wdata;
			state_next.hi_written = 1'b1;
			state_next.hold = 1'b1;
		end else if (wr_lo && state_reg.hi_written) begin
			state_next.count = {state_reg.hi_pending, wdata};
			state_next.hi_written = 1'b0;
			state_next.hold = 1'b1;
		end else if (wr_lo) begin
			state_next.hold = 1'b1;
		end
		// The pending high byte waits across idle bus cycles for its low half.
		if (rd_hi) begin
			state_next.hi_written = 1'b0;
		end
		state_next.tick_q = tap;
		if (state_reg.tick_q && !tap) begin
			state_next.phase = state_reg.phase + 4'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	// Falling edge of the tap clocks the shifters.
	assign tick.sample_tick = state_reg.tick_q && !tap;
	assign tick.sample_phase = state_reg.phase;
	assign count = state_reg.count;
	assign lo_latch = state_reg.lo_latch;

	chk_preset_hi : assert property (@(posedge pclk) disable iff (!presetn)
		wr_hi |=> count == `FRC_PRESET)
		else $error("counter not preset after high write");
	chk_latch_lo : assert property (@(posedge pclk) disable iff (!presetn)
		rd_hi |=> lo_latch == $past(count[7:0]))
		else $error("low byte not latched");
endmodule

// ===== rtl/serial_unit.sv
// Serial transmit and receive unit clocked from the free-running counter, APB slave.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "serial_consts.svh"
// Operation
// - Shift clock derived from free-running counter
// - Counter write stalls counting, changes rate
// - Enable sends ten ones before data
// - Flag shows transmit holding register empty
// - Write while full replaces pending byte
// - Receiver samples at eight times baud
// - Sample on falling edge of sample clock
// - High read latches low byte coherently
// - High byte write alone presets FFF8
// - Two-byte store loads arbitrary value
module serial_unit (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_pin,
	output logic             tx_pin,
	output logic             irq
);
	typedef struct packed {
		logic [31:0]                prdata;
		logic                       pready;
		logic                       pslverr;
		logic [7:0]                 rate;
		logic                       tx_en;
		logic                       rx_en;
		logic [7:0]                 tx_hold;
		logic                       tx_empty;
		serial_pkg::tx_state_e      tx_state;
		logic [8:0]                 tx_shift;
		logic [3:0]                 tx_bits;
		logic [2:0]                 tx_sub;
		logic                       tx_pin;
		serial_pkg::rx_state_e      rx_state;
		logic [7:0]                 rx_shift;
		logic [7:0]                 rx_data;
		logic                       rx_full;
		logic [3:0]                 rx_bits;
		logic [2:0]                 rx_sub;
		logic                       rx_s1;
		logic                       rx_s2;
		logic [3:0]                 irq_status;
		logic [3:0]                 irq_enable;
		logic                       irq;
	} unit_s;

	unit_s       state_reg;
	unit_s       state_next;
	rate_tick_if tick_bus ();
	logic [15:0] count;
	logic [7:0]  lo_latch;
	logic [7:0]  idx;
	logic        acc;
	logic        wr;
	logic        rd;
	logic        stick;
	logic [3:0]  events;
	logic        prev_hi_read;

	// ==========================================================================
	// Bus decode
	// The slave answers in the second access cycle, so pready rises one edge after penable.
	assign idx = paddr[9:2];
	assign acc = psel && penable && !state_reg.pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign stick = tick_bus.sample_tick;

	free_run_counter frc_inst (
		.pclk     (pclk),
		.presetn  (presetn),
		.rd_hi    (rd && idx == `IDX_FRC_HI),
		.wr_hi    (wr && idx == `IDX_FRC_HI),
		.wr_lo    (wr && idx == `IDX_FRC_LO),
		.wdata    (pwdata[7:0]),
		.rate_sel (state_reg.rate),
		.count    (count),
		.lo_latch (lo_latch),
		.tick     (tick_bus.source)
	);

	// ==========================================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		events = 4'h0;
		state_next.pready = acc;
		state_next.pslverr = 1'b0;
		state_next.rx_s1 = rx_pin;
		state_next.rx_s2 = state_reg.rx_s1;
		if (rd) begin
			unique case (idx)
				`IDX_FRC_HI:     state_next.prdata = {24'h000000, count[15:8]};
				`IDX_FRC_LO:     state_next.prdata = {24'h000000,
					prev_hi_read ? lo_latch : count[7:0]};
				`IDX_RATE:       state_next.prdata = {24'h000000, state_reg.rate};
				`IDX_XFER:       state_next.prdata = {26'h0000000,
					state_reg.rx_state != serial_pkg::RX_IDLE,
					state_reg.tx_state != serial_pkg::TX_IDLE,
					state_reg.rx_full, state_reg.tx_empty,
					state_reg.rx_en, state_reg.tx_en};
				`IDX_RX_DATA:    state_next.prdata = {24'h000000, state_reg.rx_data};
				`IDX_IRQ_STATUS: state_next.prdata = {28'h0000000, state_reg.irq_status};
				`IDX_IRQ_ENABLE: state_next.prdata = {28'h0000000, state_reg.irq_enable};
				default: begin
					state_next.prdata = 32'h00000000;
					state_next.pslverr = 1'b1;
				end
			endcase
			if (idx == `IDX_RX_DATA) begin
				state_next.rx_full = 1'b0;
			end
		end else if (acc) begin
			state_next.prdata = 32'h00000000;
		end
		// ======================================================================
		// Transmitter
		if (state_reg.tx_state == serial_pkg::TX_IDLE && state_reg.tx_en &&
				!state_reg.tx_empty && stick && state_reg.tx_sub == 3'h7) begin
			state_next.tx_state = serial_pkg::TX_SHIFT;
			state_next.tx_shift = {state_reg.tx_hold, 1'b0};
			state_next.tx_bits = 4'h0;
			state_next.tx_sub = 3'h0;
			state_next.tx_empty = 1'b1;
			events[`IRQ_TX_EMPTY_BIT] = 1'b1;
		end else if (stick) begin
			state_next.tx_sub = state_reg.tx_sub + 3'h1;
			if (state_reg.tx_sub == 3'h7 && state_reg.tx_state != serial_pkg::TX_IDLE) begin
				state_next.tx_bits = state_reg.tx_bits + 4'h1;
				state_next.tx_shift = {1'b1, state_reg.tx_shift[8:1]};
				if (state_reg.tx_bits == `FRAME_BITS - 4'h1) begin
					state_next.tx_state = serial_pkg::TX_IDLE;
				end
			end
		end
		unique case (state_reg.tx_state)
			serial_pkg::TX_IDLE:     state_next.tx_pin = 1'b1;
			serial_pkg::TX_PREAMBLE: state_next.tx_pin = 1'b1;
			serial_pkg::TX_SHIFT:    state_next.tx_pin = state_reg.tx_shift[0];
			default:                 state_next.tx_pin = 1'b1;
		endcase
		// ======================================================================
		// Receiver: eight samples per bit, middle sample taken.
		if (stick && state_reg.rx_en) begin
			state_next.rx_sub = state_reg.rx_sub + 3'h1;
			unique case (state_reg.rx_state)
				serial_pkg::RX_IDLE: begin
					if (!state_reg.rx_s2) begin
						state_next.rx_state = serial_pkg::RX_START;
						state_next.rx_sub = 3'h1;
					end
				end
				serial_pkg::RX_START: begin
					if (state_reg.rx_sub == `MID_SAMPLE) begin
						state_next.rx_state = state_reg.rx_s2 ? serial_pkg::RX_IDLE :
							serial_pkg::RX_DATA;
						state_next.rx_bits = 4'h0;
					end
				end
				serial_pkg::RX_DATA: begin
					if (state_reg.rx_sub == `MID_SAMPLE) begin
						state_next.rx_shift = {state_reg.rx_s2, state_reg.rx_shift[7:1]};
						state_next.rx_bits = state_reg.rx_bits + 4'h1;
						if (state_reg.rx_bits == 4'h7) begin
							state_next.rx_state = serial_pkg::RX_STOP;
						end
					end
				end
				serial_pkg::RX_STOP: begin
					if (state_reg.rx_sub == `MID_SAMPLE) begin
						state_next.rx_state = serial_pkg::RX_IDLE;
						state_next.rx_data = state_reg.rx_shift;
						state_next.rx_full = 1'b1;
						events[`IRQ_RX_FULL_BIT] = 1'b1;
						events[`IRQ_OVERRUN_BIT] = state_reg.rx_full;
						events[`IRQ_FRAMING_BIT] = !state_reg.rx_s2;
					end
				end
			endcase
		end
		// ======================================================================
		// Register writes
		if (wr) begin
			unique case (idx)
				`IDX_RATE: state_next.rate = pwdata[7:0];
				`IDX_XFER: begin
					state_next.tx_en = pwdata[`XFER_TX_EN_BIT];
					state_next.rx_en = pwdata[`XFER_RX_EN_BIT];
					if (pwdata[`XFER_TX_EN_BIT] && !state_reg.tx_en) begin
						state_next.tx_state = serial_pkg::TX_PREAMBLE;
						state_next.tx_bits = 4'h0;
						state_next.tx_sub = 3'h0;
					end
					if (!pwdata[`XFER_TX_EN_BIT]) begin
						state_next.tx_state = serial_pkg::TX_IDLE;
					end
				end
				`IDX_TX_DATA: begin
					state_next.tx_hold = pwdata[7:0];
					state_next.tx_empty = 1'b0;
				end
				`IDX_IRQ_CLEAR:  state_next.irq_status = state_reg.irq_status & ~pwdata[3:0];
				`IDX_IRQ_ENABLE: state_next.irq_enable = pwdata[3:0];
				`IDX_FRC_HI, `IDX_FRC_LO: ;
				default: state_next.pslverr = 1'b1;
			endcase
		end
		// Hardware events win over a clear in the same cycle.
		state_next.irq_status = state_next.irq_status | events;
		state_next.irq = |(state_next.irq_status & state_next.irq_enable);
	end

	// ==========================================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			state_reg.tx_empty <= 1'b1;
			state_reg.tx_pin <= 1'b1;
			state_reg.rx_s1 <= 1'b1;
			state_reg.rx_s2 <= 1'b1;
			state_reg.rate <= `RATE_RESET;
			prev_hi_read <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (rd) begin
				prev_hi_read <= idx == `IDX_FRC_HI;
			end
		end
	end

	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign tx_pin = state_reg.tx_pin;
	assign irq = state_reg.irq;

	// ==========================================================================
	// Checks
	chk_tx_holdwrite : assert property (@(posedge pclk) disable iff (!presetn)
		(wr && idx == `IDX_TX_DATA) |=> (!state_reg.tx_empty &&
		state_reg.tx_hold == $past(pwdata[7:0])))
		else $error("holding register not replaced");
	chk_preamble_high : assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg.tx_state == serial_pkg::TX_PREAMBLE) |=> tx_pin)
		else $error("line not high during preamble");
	chk_start_low : assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state_reg.tx_state == serial_pkg::TX_SHIFT) |=> !tx_pin)
		else $error("start bit not low");
	chk_empty_flag : assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state_reg.tx_state == serial_pkg::TX_SHIFT) |-> state_reg.tx_empty)
		else $error("empty not set on load");
	chk_rx_tick : assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg.rx_sub != $past(state_reg.rx_sub)) |-> $past(stick))
		else $error("receiver moved without tick");
	chk_frc_hold : assert property (@(posedge pclk) disable iff (!presetn)
		(wr && idx == `IDX_FRC_LO) |=> ##1 $stable(count))
		else $error("counter did not stall after write");
	chk_apb_ready : assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready) |=> pready)
		else $error("no answer one cycle after access");
	chk_irq_level : assert property (@(posedge pclk) disable iff (!presetn)
		irq == $past(|(state_next.irq_status & state_next.irq_enable)))
		else $error("interrupt level wrong");
	cov_tx_frame : cover property (@(posedge pclk) disable iff (!presetn)
		$fell(state_reg.tx_state == serial_pkg::TX_SHIFT));
	cov_rx_byte : cover property (@(posedge pclk) disable iff (!presetn)
		$rose(state_reg.rx_full));
	cov_overwrite : cover property (@(posedge pclk) disable iff (!presetn)
		wr && idx == `IDX_TX_DATA && !state_reg.tx_empty);
endmodule

// ===== dv/serial_partner.sv
// Remote serial partner: sends frames on the receive line and decodes the transmit line.
`timescale 1ns/1ns
module serial_partner (
	input  wire logic        pclk,
	input  wire logic        line_in,
	input  wire logic [15:0] bit_cycles,
	output logic             line_out
);
	logic [7:0] rx_byte;
	logic [7:0] sh;
	int         rx_count;

	initial begin
		line_out = 1'h1;
		rx_count = 0;
		rx_byte = 8'h00;
		sh = 8'h00;
	end

	// ==========================================================================
	// Sender
	// The line is left high after the stop bit, which is the idle level.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			@(posedge pclk);
			line_out <= f[i];
			repeat (bit_cycles - 16'h0001) @(posedge pclk);
		end
	endtask

	// ==========================================================================
	// Receiver
	// Sampling mid-bit tolerates the tick alignment of the transmitter.
	always begin
		@(negedge line_in);
		repeat (bit_cycles / 16'h0002) @(posedge pclk);
		if (line_in === 1'h0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (bit_cycles) @(posedge pclk);
				sh[i] = line_in;
			end
			repeat (bit_cycles) @(posedge pclk);
			if (line_in === 1'h1) begin
				rx_byte = sh;
				rx_count = rx_count + 1;
			end
		end
	end
endmodule

// ===== dv/tb.sv
// Self-checking bench for the serial unit: registers, counter, transmit and receive.
`timescale 1ns/1ns
`include "serial_consts.svh"
module tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_pin;
	logic        tx_pin;
	logic        irq;
	logic [15:0] bit_cycles;
	logic [31:0] rd;
	logic        rerr;
	logic [15:0] cnt;
	int          err_count;
	int          check_count;
	int          cyc;
	int          t0;
	int          n;

	serial_unit serial_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
		.tx_pin(tx_pin), .irq(irq));
	serial_partner serial_partner_i (.pclk(pclk), .line_in(tx_pin),
		.bit_cycles(bit_cycles), .line_out(rx_pin));

	always #10 pclk = ~pclk;

	// ==========================================================================
	// Timeout
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			complete_run;
		end
	end

	// ==========================================================================
	// Tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// A low read with another register read since the high read would tear at a byte carry.
	task automatic read_count();
		apb(1'h0, `IDX_FRC_HI, 32'h0);
		cnt[15:8] = rd[7:0];
		apb(1'h0, `IDX_FRC_LO, 32'h0);
		cnt[7:0] = rd[7:0];
	endtask

	task complete_run;
		$display("Comparisons %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ==========================================================================
	// Sequence
	initial begin
		pclk = 1'h0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		bit_cycles = 16'h0010;
		cyc = 0;
		err_count = 0;
		check_count = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `IDX_RATE, 32'h0);
		check(rd, {24'h0, `RATE_RESET});
		apb(1'h0, `IDX_XFER, 32'h0);
		check(rd, 32'h4);
		apb(1'h0, `IDX_IRQ_ENABLE, 32'h0);
		check(rd, 32'h0);
		apb(1'h0, 8'h20, 32'h0);
		check({31'h0, rerr}, 32'h1);
		check(rd, 32'h0);
		// Counter is written only while the line is idle.
		apb(1'h1, `IDX_FRC_HI, 32'h55);
		read_count();
		check({31'h0, (cnt - `FRC_PRESET) < 16'h0010}, 32'h1);
		apb(1'h1, `IDX_FRC_HI, 32'h12);
		apb(1'h1, `IDX_FRC_LO, 32'hFC);
		read_count();
		check({31'h0, (cnt - 16'h12FC) < 16'h0010}, 32'h1);
		apb(1'h1, `IDX_RATE, 32'h0);
		apb(1'h1, `IDX_XFER, 32'h1);
		t0 = cyc;
		apb(1'h1, `IDX_TX_DATA, 32'h11);
		apb(1'h1, `IDX_TX_DATA, 32'h22);
		apb(1'h0, `IDX_XFER, 32'h0);
		check(rd & 32'h4, 32'h0);
		while (tx_pin !== 1'h0) @(posedge pclk);
		check({31'h0, (cyc - t0) >= 155 && (cyc - t0) <= 185}, 32'h1);
		while (serial_partner_i.rx_count < 1) @(posedge pclk);
		check({24'h0, serial_partner_i.rx_byte}, 32'h22);
		repeat (400) @(posedge pclk);
		check(serial_partner_i.rx_count, 32'h1);
		apb(1'h0, `IDX_XFER, 32'h0);
		check(rd & 32'h4, 32'h4);
		apb(1'h1, `IDX_RATE, 32'h1);
		bit_cycles <= 16'h0020;
		apb(1'h1, `IDX_TX_DATA, 32'h96);
		while (serial_partner_i.rx_count < 2) @(posedge pclk);
		check({24'h0, serial_partner_i.rx_byte}, 32'h96);
		apb(1'h1, `IDX_XFER, 32'h3);
		apb(1'h1, `IDX_IRQ_ENABLE, 32'h2);
		serial_partner_i.send_byte(8'h3C);
		n = 0;
		while (irq !== 1'h1 && n < 64) begin
			@(posedge pclk);
			n = n + 1;
		end
		check({31'h0, irq}, 32'h1);
		apb(1'h0, `IDX_IRQ_STATUS, 32'h0);
		check(rd & 32'h2, 32'h2);
		apb(1'h0, `IDX_RX_DATA, 32'h0);
		check(rd & 32'hFF, 32'h3C);
		apb(1'h1, `IDX_IRQ_CLEAR, 32'h2);
		apb(1'h0, `IDX_IRQ_STATUS, 32'h0);
		check(rd & 32'h2, 32'h0);
		check({31'h0, irq}, 32'h0);
		apb(1'h1, `IDX_IRQ_ENABLE, 32'h0);
		serial_partner_i.send_byte(8'hC3);
		repeat (8) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		apb(1'h0, `IDX_IRQ_STATUS, 32'h0);
		check(rd & 32'h2, 32'h2);
		apb(1'h0, `IDX_RX_DATA, 32'h0);
		check(rd & 32'hFF, 32'hC3);
		complete_run;
	end
endmodule
